// [rtl/pxs_bus_if.sv]
// Register bus between the host controller and the register group
`timescale 1ns/100ps
`default_nettype none
interface pxs_bus_if;
  logic [pxs_pkg::ADDR_W-1:0] addr;
  logic [31:0]                wdata;
  logic                       wr;
  logic                       rd;
  logic [31:0]                rdata;

  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host   (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// [rtl/pxs_host.sv]
// Host end: forwards software accesses and screens fog and init writes
`timescale 1ns/100ps
`default_nettype none
module pxs_host
  import pxs_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  pxs_bus_if.host                       bus,
  input  wire logic [pxs_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [31:0]              cmd_wdata,
  input  wire logic                     cmd_wr,
  input  wire logic                     cmd_rd,
  input  wire logic                     engine_busy,
  output var  logic [31:0]              cmd_rdata,
  output var  logic                     fog_reject,
  output var  logic                     init_reject
);
  import pxs_pkg::*;

  // ************************************************************
  // Write screening
  // ************************************************************
  logic [7:0] off;
  logic       own_reg;
  logic       is_fog;
  logic       is_init;
  logic       fog_bad;
  logic       init_bad;
  logic       drop;

  // Checks one packed factor/delta pair
  function automatic logic pair_bad(input logic [15:0] pair);
    pair_bad = (pair[7:0] > FOG_DELTA_MAX)
            || ({1'b0, pair[15:8]} + {1'b0, pair[7:0]} > FOG_SUM_MAX);
  endfunction

  assign off      = cmd_addr[7:0];
  assign own_reg  = (off == OFF_HOST_STAT);
  assign is_fog   = (off >= OFF_FOG_BASE) && (off <= OFF_FOG_LAST);
  assign is_init  = (off == OFF_INIT0) || (off == OFF_INIT1);
  // Swapped words are not screened: the swap setting lives in the device
  assign fog_bad  = is_fog && !cmd_addr[SWAP_BIT]
                 && (pair_bad(cmd_wdata[15:0]) || pair_bad(cmd_wdata[31:16]));
  assign init_bad = is_init && engine_busy;
  assign drop     = own_reg || fog_bad || init_bad;

  assign bus.addr  = cmd_addr;
  assign bus.wdata = cmd_wdata;
  assign bus.wr    = cmd_wr && !drop;
  assign bus.rd    = cmd_rd && !own_reg;

  // ************************************************************
  // Sticky reject flags, write one to clear, a new event wins
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
      fog_reject <= 1'b0;
    else if (cmd_wr && fog_bad)
      fog_reject <= 1'b1;
    else if (cmd_wr && own_reg && cmd_wdata[0])
      fog_reject <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      init_reject <= 1'b0;
    else if (cmd_wr && init_bad)
      init_reject <= 1'b1;
    else if (cmd_wr && own_reg && cmd_wdata[1])
      init_reject <= 1'b0;
  end

  // ************************************************************
  // Read data, one cycle after the strobe
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cmd_rdata <= 32'h00000000;
    else if (cmd_rd)
      cmd_rdata <= own_reg ? {30'h0, init_reject, fog_reject} : bus.rdata;
  end

endmodule // pxs_host
`default_nettype wire

// [rtl/pxs_pkg.sv]
// Shared constants for the pixel statistics and video init register group
package pxs_pkg;

  // ************************************************************
  // Bus shape
  // ************************************************************
  localparam int ADDR_W   = 22;
  localparam int SWAP_BIT = 21;

  // ************************************************************
  // Register offsets (byte address bits 7:0)
  // ************************************************************
  localparam logic [7:0] OFF_ALPHA_FAIL = 8'h00;
  localparam logic [7:0] OFF_DRAWN      = 8'h04;
  localparam logic [7:0] OFF_NOP_CMD    = 8'h08;
  localparam logic [7:0] OFF_FOG_BASE   = 8'h40;
  localparam logic [7:0] OFF_FOG_LAST   = 8'hBC;
  localparam logic [7:0] OFF_VPOS       = 8'hC0;
  localparam logic [7:0] OFF_HSYNC      = 8'hC4;
  localparam logic [7:0] OFF_VSYNC      = 8'hC8;
  localparam logic [7:0] OFF_PORCH      = 8'hCC;
  localparam logic [7:0] OFF_SIZE       = 8'hD0;
  localparam logic [7:0] OFF_INIT0      = 8'hD4;
  localparam logic [7:0] OFF_INIT1      = 8'hD8;
  localparam logic [7:0] OFF_HOST_STAT  = 8'hFC;

  // ************************************************************
  // Field layouts, masks and reset values
  // ************************************************************
  localparam int CNT_W       = 24;
  localparam int FOG_WORDS   = 32;
  localparam int VPOS_W      = 12;
  localparam logic [31:0] HSYNC_MASK = 32'h03FF00FF;
  localparam logic [31:0] VSYNC_MASK = 32'h0FFF0FFF;
  localparam logic [31:0] PORCH_MASK = 32'h00FF00FF;
  localparam logic [31:0] SIZE_MASK  = 32'h03FF03FF;
  localparam logic [31:0] TIMING_RST = 32'h00000000;
  localparam logic [31:0] INIT0_MASK = 32'h7FFFFFDF;
  localparam logic [31:0] INIT0_RST  = 32'h00000410;
  localparam logic [31:0] INIT1_MASK = 32'h7EFFFFFA;
  localparam logic [31:0] INIT1_RST  = 32'h00201102;
  localparam int I0_VGA       = 0;
  localparam int I0_GFX_RST   = 1;
  localparam int I0_FIFO_RST  = 2;
  localparam int I0_SWAP      = 3;
  localparam int I0_STALL     = 4;
  localparam int I0_LWM_LO    = 6;
  localparam int I0_LFB_MEM   = 11;
  localparam int I0_TEX_MEM   = 12;
  localparam int I0_MEM_EN    = 13;
  localparam int I0_HWM_LO    = 14;
  localparam int I0_BURST_LO  = 25;
  localparam int I1_FUNC_NUM  = 0;
  localparam int I1_WAIT      = 1;
  localparam int I1_TWO_CHIP  = 2;
  localparam int I1_LFB_RD    = 3;
  localparam int I1_VID_RST   = 8;
  localparam int I1_SYNC_OVR  = 9;
  localparam int I1_HSYNC_VAL = 10;
  localparam int I1_VSYNC_VAL = 11;
  localparam int I1_BLANK     = 12;
  localparam int I1_DRV_DATA  = 13;
  localparam int I1_DRV_BLANK = 14;
  localparam int I1_DRV_SYNC  = 15;
  localparam int I1_DRV_DCLK  = 16;
  localparam logic [7:0] FOG_DELTA_MAX = 8'h3F;
  localparam logic [8:0] FOG_SUM_MAX   = 9'h0FF;

endpackage

// [rtl/pxs_regs.sv]
// Device end: statistics counters, fog table, video timing and init registers
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pxs_regs
  import pxs_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     nrst,
  pxs_bus_if.device                     bus,
  input  wire logic                     init_write_enable,
  input  wire logic                     alpha_fail_pulse,
  input  wire logic                     pixel_drawn_pulse,
  input  wire logic [pxs_pkg::VPOS_W-1:0] vsync_off_count,
  input  wire logic [5:0]               fog_index,
  input  wire logic                     strap_vga_pin,
  input  wire logic                     strap_func_pin,
  input  wire logic                     strap_two_chip_pin,
  input  wire logic                     hsync_gen,
  input  wire logic                     vsync_gen,
  input  wire logic                     blank_gen,
  input  wire logic [23:0]              video_data_gen,
  input  wire logic                     dclk_gen,
  output var  logic [7:0]               fog_factor,
  output var  logic [7:0]               fog_delta,
  output var  logic [31:0]              horiz_sync_timing,
  output var  logic [31:0]              vert_sync_timing,
  output var  logic [31:0]              porch_timing,
  output var  logic [31:0]              active_size,
  output var  logic [31:0]              init_fifo_control,
  output var  logic [31:0]              init_bus_video_control,
  output var  logic                     video_timing_reset,
  output var  logic [23:0]              video_data_out,
  output var  logic                     video_data_oe,
  output var  logic                     blank_out,
  output var  logic                     blank_oe,
  output var  logic                     hsync_out,
  output var  logic                     vsync_out,
  output var  logic                     sync_oe,
  output var  logic                     dclk_out,
  output var  logic                     dclk_oe
);
  import pxs_pkg::*;

  // ************************************************************
  // Strap synchronisers
  // ************************************************************
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [2:0] strap_s3;
  logic [2:0] strap_now;
  logic       func_num;
  logic       two_chip;

  always_ff @(posedge clk)
  begin
    strap_s1 <= {strap_two_chip_pin, strap_func_pin, strap_vga_pin};
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // A strap counts once stages two and three agree
  // Not reset, so the pins are already settled when reset latches them
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
      if (strap_s2[i] == strap_s3[i])
        strap_now[i] <= strap_s3[i];
  end

  // Straps are latched while reset is held
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      func_num <= strap_now[1];
      two_chip <= strap_now[2];
    end
  end

  // ************************************************************
  // Write decode
  // ************************************************************
  logic [7:0]  off;
  logic [31:0] wd;
  logic        init_ok;
  logic        cnt_clear;

  assign off = bus.addr[7:0];
  assign wd  = (init_fifo_control[I0_SWAP] && bus.addr[SWAP_BIT])
             ? {bus.wdata[7:0], bus.wdata[15:8], bus.wdata[23:16], bus.wdata[31:24]}
             : bus.wdata;
  assign init_ok   = bus.wr && init_write_enable;
  assign cnt_clear = bus.wr && (off == OFF_NOP_CMD) && wd[0];

  // ************************************************************
  // Statistics counters
  // ************************************************************
  logic [CNT_W-1:0] alpha_fail_count;
  logic [CNT_W-1:0] drawn_pixel_count;

  // Clear and a same-cycle event leave a count of one
  always_ff @(posedge clk)
  begin
    if (!nrst)
      alpha_fail_count <= '0;
    else if (cnt_clear)
      alpha_fail_count <= {{(CNT_W-1){1'b0}}, alpha_fail_pulse};
    else if (alpha_fail_pulse)
      alpha_fail_count <= alpha_fail_count + 1'b1;
  end

  // Mask control bit 9 is deliberately not an input here
  always_ff @(posedge clk)
  begin
    if (!nrst)
      drawn_pixel_count <= '0;
    else if (cnt_clear)
      drawn_pixel_count <= {{(CNT_W-1){1'b0}}, pixel_drawn_pulse};
    else if (pixel_drawn_pulse)
      drawn_pixel_count <= drawn_pixel_count + 1'b1;
  end

  // ************************************************************
  // Fog table
  // ************************************************************
  logic [31:0] fog_mem [0:FOG_WORDS-1];
  logic [31:0] fog_word;
  logic [7:0]  fog_rel;

  // Word index counts from the table base, not from address zero
  assign fog_rel = off - OFF_FOG_BASE;

  always_ff @(posedge clk)
  begin
    if (bus.wr && off >= OFF_FOG_BASE && off <= OFF_FOG_LAST)
      fog_mem[fog_rel[6:2]] <= wd;
  end

  // Even entry in the low half, odd entry in the high half
  assign fog_word = fog_mem[fog_index[5:1]];

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      fog_factor <= 8'h00;
      fog_delta  <= 8'h00;
    end
    else
    begin
      fog_factor <= fog_index[0] ? fog_word[31:24] : fog_word[15:8];
      fog_delta  <= fog_index[0] ? fog_word[23:16] : fog_word[7:0];
    end
  end

  // ************************************************************
  // Video timing registers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      horiz_sync_timing <= TIMING_RST;
      vert_sync_timing  <= TIMING_RST;
      porch_timing      <= TIMING_RST;
      active_size       <= TIMING_RST;
    end
    else if (bus.wr)
    begin
      if (off == OFF_HSYNC)
        horiz_sync_timing <= wd & HSYNC_MASK;
      if (off == OFF_VSYNC)
        vert_sync_timing <= wd & VSYNC_MASK;
      if (off == OFF_PORCH)
        porch_timing <= wd & PORCH_MASK;
      if (off == OFF_SIZE)
        active_size <= wd & SIZE_MASK;
    end
  end

  // ************************************************************
  // Initialization registers
  // ************************************************************
  // Written straight into the register, no queueing behind the FIFO
  always_ff @(posedge clk)
  begin
    if (!nrst)
      init_fifo_control <= INIT0_RST | {31'h0, strap_now[0]};
    else if (init_ok && off == OFF_INIT0)
      init_fifo_control <= wd & INIT0_MASK;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      init_bus_video_control <= INIT1_RST;
    else if (init_ok && off == OFF_INIT1)
      init_bus_video_control <= wd & INIT1_MASK;
  end

  // ************************************************************
  // Video output stage
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      video_timing_reset <= 1'b1;
      hsync_out          <= 1'b0;
      vsync_out          <= 1'b0;
      blank_out          <= 1'b1;
      video_data_out     <= 24'h000000;
      dclk_out           <= 1'b0;
      video_data_oe      <= 1'b0;
      blank_oe           <= 1'b0;
      sync_oe            <= 1'b0;
      dclk_oe            <= 1'b0;
    end
    else
    begin
      video_timing_reset <= init_bus_video_control[I1_VID_RST];
      hsync_out <= init_bus_video_control[I1_SYNC_OVR]
                 ? init_bus_video_control[I1_HSYNC_VAL] : hsync_gen;
      vsync_out <= init_bus_video_control[I1_SYNC_OVR]
                 ? init_bus_video_control[I1_VSYNC_VAL] : vsync_gen;
      blank_out      <= init_bus_video_control[I1_BLANK] | blank_gen;
      video_data_out <= video_data_gen;
      dclk_out       <= dclk_gen;
      video_data_oe  <= init_bus_video_control[I1_DRV_DATA];
      blank_oe       <= init_bus_video_control[I1_DRV_BLANK];
      sync_oe        <= init_bus_video_control[I1_DRV_SYNC];
      dclk_oe        <= init_bus_video_control[I1_DRV_DCLK];
    end
  end

  // ************************************************************
  // Read mux, answered in the strobe cycle
  // ************************************************************
  always_comb
  begin
    bus.rdata = 32'h00000000;
    if (bus.rd)
    begin
      case (off)
        OFF_ALPHA_FAIL: bus.rdata = {8'h00, alpha_fail_count};
        OFF_DRAWN:      bus.rdata = {8'h00, drawn_pixel_count};
        OFF_VPOS:       bus.rdata = {20'h00000, vsync_off_count};
        OFF_HSYNC:      bus.rdata = horiz_sync_timing;
        OFF_VSYNC:      bus.rdata = vert_sync_timing;
        OFF_PORCH:      bus.rdata = porch_timing;
        OFF_SIZE:       bus.rdata = active_size;
        OFF_INIT0:      bus.rdata = init_fifo_control;
        OFF_INIT1:      bus.rdata = init_bus_video_control
                                  | ({31'h0, func_num} << I1_FUNC_NUM)
                                  | ({31'h0, two_chip} << I1_TWO_CHIP);
        default:        bus.rdata = 32'h00000000;
      endcase
    end
  end

endmodule // pxs_regs
`default_nettype wire

// [tb/pxs_sva.sv]
// Bus checker for the register group interface
`timescale 1ns/100ps
`default_nettype none
module pxs_sva
  import pxs_pkg::*;
(
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic [pxs_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0]                wdata,
  input wire logic                       wr,
  input wire logic                       rd,
  input wire logic [31:0]                rdata
);
  import pxs_pkg::*;
  wire [7:0] a8 = addr[7:0];
  wire       fog_wr = wr && !addr[21] && a8 >= OFF_FOG_BASE && a8 <= OFF_FOG_LAST;
  wire       cnt_rd = rd && (a8 == OFF_ALPHA_FAIL || a8 == OFF_DRAWN);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // *****
  // Read data layout
  // *****
  a_alpha_width: assert property (rd && a8 == OFF_ALPHA_FAIL |-> rdata[31:24] == 8'h0)
    else $error("alpha count above 24 bits");
  a_drawn_width: assert property (rd && a8 == OFF_DRAWN |-> rdata[31:24] == 8'h0)
    else $error("drawn count above 24 bits");
  a_vpos_width: assert property (rd && a8 == OFF_VPOS |-> rdata[31:12] == 20'h0)
    else $error("vertical position above 12 bits");
  a_hsync_rsvd: assert property (rd && a8 == OFF_HSYNC |-> (rdata & ~32'h03FF00FF) == 32'h0)
    else $error("hsync reserved bits set");
  a_vsync_rsvd: assert property (rd && a8 == OFF_VSYNC |-> (rdata & ~32'h0FFF0FFF) == 32'h0)
    else $error("vsync reserved bits set");
  a_porch_rsvd: assert property (rd && a8 == OFF_PORCH |-> (rdata & ~32'h00FF00FF) == 32'h0)
    else $error("porch reserved bits set");
  a_size_rsvd: assert property (rd && a8 == OFF_SIZE |-> (rdata & ~32'h03FF03FF) == 32'h0)
    else $error("size reserved bits set");
  // *****
  // Counter clear and fog screening
  // *****
  a_nop_clear: assert property ((wr && !addr[21] && a8 == OFF_NOP_CMD && wdata[0]) ##[1:4] cnt_rd
    |-> rdata <= 32'h5) else $error("counter not cleared");
  a_fog_delta: assert property (fog_wr |-> wdata[7:0] <= 8'h3F && wdata[23:16] <= 8'h3F)
    else $error("fog delta over limit");
  a_fog_sum: assert property (fog_wr |-> {1'b0, wdata[15:8]} + {1'b0, wdata[7:0]} <= 9'h0FF
    && {1'b0, wdata[31:24]} + {1'b0, wdata[23:16]} <= 9'h0FF) else $error("fog sum over limit");
endmodule // pxs_sva
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench with both ends of the register group joined
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pxs_pkg::*;
  logic clk, nrst, cmd_wr, cmd_rd, engine_busy, init_write_enable;
  logic alpha_fail_pulse, pixel_drawn_pulse, hsync_gen, vsync_gen, blank_gen, dclk_gen;
  logic [ADDR_W-1:0] cmd_addr;
  logic [31:0] cmd_wdata, cmd_rdata, r, horiz_sync_timing;
  logic [11:0] vsync_off_count;
  logic [5:0] fog_index;
  logic [23:0] video_data_gen, video_data_out;
  logic [7:0] fog_factor, fog_delta;
  logic video_timing_reset, video_data_oe, blank_out, blank_oe, hsync_out, vsync_out;
  logic sync_oe, dclk_out, dclk_oe, fog_reject, init_reject;
  logic strap_vga, strap_func, strap_two;
  int mismatches, n_checks;
  pxs_bus_if bus ();
  pxs_regs pxs_regs_inst (.clk, .nrst, .bus, .init_write_enable, .alpha_fail_pulse,
    .pixel_drawn_pulse, .vsync_off_count, .fog_index, .strap_vga_pin(strap_vga),
    .strap_func_pin(strap_func), .strap_two_chip_pin(strap_two), .hsync_gen, .vsync_gen,
    .blank_gen,
    .video_data_gen, .dclk_gen, .fog_factor, .fog_delta, .horiz_sync_timing,
    .vert_sync_timing(), .porch_timing(), .active_size(), .init_fifo_control(),
    .init_bus_video_control(), .video_timing_reset, .video_data_out, .video_data_oe,
    .blank_out, .blank_oe, .hsync_out, .vsync_out, .sync_oe, .dclk_out, .dclk_oe);
  pxs_host pxs_host_inst (.clk, .nrst, .bus, .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd,
    .engine_busy, .cmd_rdata, .fog_reject, .init_reject);
  pxs_sva pxs_sva_inst (.clk, .nrst, .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
    .rd(bus.rd), .rdata(bus.rdata));
  // *****
  // Bus and compare tasks
  // *****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bw(input logic [21:0] a, input logic [31:0] d);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_wr <= 1'b0;
  endtask
  task automatic rc(input logic [21:0] a, input logic [31:0] e);
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_addr <= a;
    @(posedge clk);
    cmd_rd <= 1'b0;
    #1 chk(cmd_rdata, e);
  endtask
  task automatic fe(input logic [5:0] k, input logic [15:0] e);
    @(posedge clk);
    fog_index <= k;
    @(posedge clk);
    #1 chk({16'h0, fog_factor, fog_delta}, {16'h0, e});
  endtask
  task automatic pulses(input int na, input int nd);
    for (int i = 0; i < na || i < nd; i++)
    begin
      @(posedge clk);
      alpha_fail_pulse <= (i < na);
      pixel_drawn_pulse <= (i < nd);
    end
    @(posedge clk);
    alpha_fail_pulse <= 1'b0;
    pixel_drawn_pulse <= 1'b0;
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_reset();
    rc(OFF_INIT0, 32'h00000411);
    rc(OFF_INIT1, 32'h00201103);
    rc(OFF_ALPHA_FAIL, 32'h0);
    rc(OFF_DRAWN, 32'h0);
    rc(8'hF0, 32'h0);
    chk(32'(video_timing_reset), 32'h1);
    chk(32'(blank_out), 32'h1);
    chk({28'h0, video_data_oe, blank_oe, sync_oe, dclk_oe}, 32'h0);
    chk({29'h0, hsync_out, vsync_out, dclk_out}, 32'h3);
  endtask
  task automatic t_timing();
    logic [7:0] offs [4];
    logic [31:0] msk [4];
    offs = '{OFF_HSYNC, OFF_VSYNC, OFF_PORCH, OFF_SIZE};
    msk = '{32'h03FF00FF, 32'h0FFF0FFF, 32'h00FF00FF, 32'h03FF03FF};
    for (int i = 0; i < 4; i++)
    begin
      bw(offs[i], 32'hFFFFFFFF);
      rc(offs[i], msk[i]);
      bw(offs[i], 32'h0);
      rc(offs[i], 32'h0);
    end
    bw(OFF_HSYNC, 32'h00A50012);
    #1 chk(horiz_sync_timing, 32'h00A50012);
  endtask
  task automatic t_count();
    pulses(5, 9);
    rc(OFF_ALPHA_FAIL, 32'h5);
    rc(OFF_DRAWN, 32'h9);
    rc(OFF_DRAWN, 32'h9);
    bw(OFF_NOP_CMD, 32'h2);
    rc(OFF_DRAWN, 32'h9);
    bw(OFF_NOP_CMD, 32'h1);
    rc(OFF_ALPHA_FAIL, 32'h0);
    rc(OFF_DRAWN, 32'h0);
  endtask
  task automatic t_vpos();
    @(posedge clk);
    vsync_off_count <= 12'hABC;
    rc(OFF_VPOS, 32'h00000ABC);
    bw(OFF_VPOS, 32'h00000123);
    vsync_off_count <= 12'h5A5;
    rc(OFF_VPOS, 32'h000005A5);
  endtask
  task automatic t_init();
    bw(OFF_INIT1, 32'h0001E607);
    rc(OFF_INIT1, 32'h00201103);
    init_write_enable <= 1'b1;
    engine_busy <= 1'b1;
    bw(OFF_INIT1, 32'h0001E607);
    rc(OFF_INIT1, 32'h00201103);
    chk(32'(init_reject), 32'h1);
    engine_busy <= 1'b0;
    bw(OFF_INIT1, 32'h0001E607);
    rc(OFF_INIT1, 32'h0001E603);
    chk({28'h0, hsync_out, vsync_out, blank_out, video_timing_reset}, 32'h8);
    chk({28'h0, video_data_oe, blank_oe, sync_oe, dclk_oe}, 32'hF);
    chk({8'h0, video_data_out}, 32'h005A5A5A);
    chk(32'(dclk_out), 32'h1);
  endtask
  task automatic t_swap();
    bw(OFF_INIT0, 32'h0000041E);
    rc(OFF_INIT0, 32'h0000041E);
    bw(OFF_INIT0, 32'h00000418);
    bw({14'h2000, OFF_HSYNC}, 32'h11223344);
    rc(OFF_HSYNC, 32'h00330011);
    bw(OFF_HSYNC, 32'h11223344);
    rc(OFF_HSYNC, 32'h01220044);
    bw(OFF_INIT0, 32'h7FFFFC10);
    rc(OFF_INIT0, 32'h7FFFFC10);
  endtask
  task automatic t_fog();
    bw(OFF_FOG_BASE, 32'h2008103F);
    bw(OFF_FOG_LAST, 32'hC03FFF00);
    fe(6'h00, 16'h103F);
    fe(6'h01, 16'h2008);
    fe(6'h3E, 16'hFF00);
    fe(6'h3F, 16'hC03F);
    chk(32'(fog_reject), 32'h0);
    bw(OFF_FOG_BASE, 32'h20081040);
    #1 chk(32'(fog_reject), 32'h1);
    fe(6'h00, 16'h103F);
    bw(OFF_FOG_BASE, 32'hF0102000);
    fe(6'h01, 16'h2008);
    rc(OFF_HOST_STAT, 32'h3);
    bw(OFF_HOST_STAT, 32'h3);
    rc(OFF_HOST_STAT, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #50000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    {nrst, cmd_wr, cmd_rd, engine_busy, init_write_enable} = 5'h0;
    {alpha_fail_pulse, pixel_drawn_pulse, hsync_gen, blank_gen} = 4'h0;
    {vsync_gen, dclk_gen} = 2'h3;
    {strap_vga, strap_func, strap_two} = 3'h6;
    cmd_addr = '0;
    cmd_wdata = 32'h0;
    vsync_off_count = 12'h0;
    fog_index = 6'h0;
    video_data_gen = 24'h5A5A5A;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_timing();
    t_count();
    t_vpos();
    t_init();
    t_swap();
    t_fog();
    complete_run();
  end
endmodule // tb
`default_nettype wire
